// ### smg_consts.svh
/*
 * constants of the sequential muting guard: register offsets, field positions,
 * reset values and timing figures.
 * assumes it is included by bare name, once per compilation unit per file.
 */
`ifndef SMG_CONSTS_SVH
`define SMG_CONSTS_SVH

// =====================================================================
// register map (byte addresses)
`define SMG_ADDR_CTRL 8'h00
`define SMG_ADDR_MAXTIME 8'h04
`define SMG_ADDR_STATUS 8'h08
`define SMG_ADDR_W 8

// =====================================================================
// control register fields
`define SMG_CTRL_W 4
`define SMG_CTRL_ACTIVATE 0
`define SMG_CTRL_PERMIT 1
`define SMG_CTRL_START_RESET 2
`define SMG_CTRL_RESET 3
`define SMG_CTRL_RESET_VAL 4'h0

// =====================================================================
// sampled input vector positions
`define SMG_IN_W 5
`define SMG_IN_ENTRY_A 0
`define SMG_IN_ENTRY_B 1
`define SMG_IN_EXIT_A 2
`define SMG_IN_EXIT_B 3
`define SMG_IN_GUARD 4
`define SMG_SYNC_RESET_VAL 5'h00

// =====================================================================
// timing: the mute timer counts in milliseconds
`define SMG_CLK_PERIOD_NS 8
`define SMG_TIMER_UNIT_NS 1000000
`define SMG_MAX_TIME_MIN 120
`define SMG_MS_PER_MIN 60000
`define SMG_TIME_W 23
`define SMG_MAXTIME_RESET_VAL 23'h000000

// =====================================================================
// bus answers and the fewest sensors active while muted
`define SMG_RESP_OKAY 2'h0
`define SMG_RESP_SLVERR 2'h2
`define SMG_MIN_ACTIVE 3'h2

`endif

// ### smg_pkg.sv
/*
 * types of the sequential muting guard: state codes and carriers.
 * assumes a 32-bit AXI4-Lite master with 8-bit byte addresses.
 */
package smg_pkg;

    // =================================================================
    // guard state, one-hot
    typedef enum logic [7:0] {
        SMG_IDLE      = 8'h01,
        SMG_FREE      = 8'h02,
        SMG_FWD_FIRST = 8'h04,
        SMG_FWD_MUTED = 8'h08,
        SMG_BWD_FIRST = 8'h10,
        SMG_BWD_MUTED = 8'h20,
        SMG_SAFE      = 8'h40,
        SMG_LOCK      = 8'h80
    } smg_state_t;

    // =================================================================
    // carriers
    typedef struct packed {
        logic mute_sensor_exit_b;
        logic mute_sensor_exit_a;
        logic mute_sensor_entry_b;
        logic mute_sensor_entry_a;
    } smg_sensor_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } smg_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } smg_axil_rsp_t;

endpackage : smg_pkg

// ### smg_input_sync.sv
/*
 * pin synchroniser with edge detect for the guard and sensor inputs.
 * assumes asynchronous pins; output follows once two later stages agree.
 */
`include "smg_consts.svh"

module smg_input_sync #(
    parameter int unsigned W = `SMG_IN_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins
    input wire logic [W-1:0] pinIn,
    // sampled view
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] prev;
    logic [W-1:0] next_level;

    // =================================================================
    // accept a change only where stages two and three agree
    always_comb begin
        next_level = (stage2 & stage3) | (level & (stage2 ^ stage3));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1 <= `SMG_SYNC_RESET_VAL;
            stage2 <= `SMG_SYNC_RESET_VAL;
            stage3 <= `SMG_SYNC_RESET_VAL;
            level <= `SMG_SYNC_RESET_VAL;
            prev <= `SMG_SYNC_RESET_VAL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
            prev <= level;
        end
    end

    // edges against the previous evaluation's sample
    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule : smg_input_sync

// ### smg_mute_timer.sv
/*
 * maximum mute time supervision, counted in milliseconds.
 * assumes run stays high for the whole muted interval and drops after it.
 */
`include "smg_consts.svh"

module smg_mute_timer #(
    parameter int unsigned TICK_CYCLES = `SMG_TIMER_UNIT_NS / `SMG_CLK_PERIOD_NS,
    parameter int unsigned TIME_W = `SMG_TIME_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [TIME_W-1:0] limit,
    // result
    output logic expired
);
    logic [31:0] tickCnt;
    logic [TIME_W-1:0] msCnt;
    logic [31:0] next_tickCnt;
    logic [TIME_W-1:0] next_msCnt;
    logic tick;

    // =================================================================
    // millisecond divider and elapsed count, cleared whenever idle
    always_comb begin
        tick = (tickCnt == TICK_CYCLES - 1);
        next_tickCnt = tick ? 32'h0 : tickCnt + 32'h1;
        next_msCnt = tick && (msCnt != {TIME_W{1'b1}}) ? msCnt + 1'b1 : msCnt;
        if (!run) begin
            next_tickCnt = 32'h0;
            next_msCnt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tickCnt <= 32'h0;
            msCnt <= '0;
        end else begin
            tickCnt <= next_tickCnt;
            msCnt <= next_msCnt;
        end
    end

    // a zero limit expires at once: the fail-safe reading
    assign expired = run && (msCnt >= limit);

endmodule : smg_mute_timer

// ### smg_sequential_muting_guard.sv
/*
 * sequential muting guard: four-sensor muting of an optical guard in either
 * direction, with AXI4-Lite control and status registers.
 * assumes guard and sensor inputs are asynchronous pins and one AXI4-Lite master.
 */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "smg_consts.svh"

module smg_sequential_muting_guard #(
    parameter int unsigned TICK_CYCLES = `SMG_TIMER_UNIT_NS / `SMG_CLK_PERIOD_NS,
    parameter logic [`SMG_TIME_W-1:0] MAX_MUTE_TIME_MS = `SMG_MAXTIME_RESET_VAL
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register bus
    input wire smg_pkg::smg_axil_req_t axiReq,
    output smg_pkg::smg_axil_rsp_t axiRsp,
    // guard and sensor pins
    input wire logic guard_ok_in,
    input wire smg_pkg::smg_sensor_t sensorIn,
    // safety outputs
    output logic guarded_out,
    output logic mute_active_out
);
    import smg_pkg::*;

    // =================================================================
    // declarations
    localparam logic [`SMG_TIME_W-1:0] MAX_TIME_LIMIT = `SMG_TIME_W'(`SMG_MAX_TIME_MIN * `SMG_MS_PER_MIN);

    logic [`SMG_IN_W-1:0] inLevel;
    logic [`SMG_IN_W-1:0] inRise;
    logic [`SMG_IN_W-1:0] inFall;
    logic [`SMG_CTRL_W-1:0] ctrl;
    logic [`SMG_CTRL_W-1:0] next_ctrl;
    logic [`SMG_TIME_W-1:0] maxTime;
    logic [`SMG_TIME_W-1:0] next_maxTime;
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic [`SMG_ADDR_W-1:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData, wMerged, rdWord;
    logic [3:0] wStrb, next_wStrb;
    smg_axil_rsp_t next_rsp;
    logic gotAw, gotW, doWrite;
    logic [`SMG_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] curWord;
    logic wrHit, rdHit;

    smg_state_t state, next_state;
    logic resetPrev, next_guarded, next_mute;
    logic s11, s12, s21, s22, guardOk, r11, r12, r21, r22, f11, f12, f21, f22;
    logic activate, permit, startReset, resetRise;
    logic [2:0] activeCnt;
    logic fwdStart, bwdStart, freeErr, fwdFirstErr, bwdFirstErr, fwdMute, bwdMute;
    logic fwdEnd, bwdEnd, fwdMutedErr, bwdMutedErr, muted, expired;

    // =================================================================
    // input sampling
    smg_input_sync #(.W(`SMG_IN_W)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn({guard_ok_in, sensorIn}),
        .level(inLevel),
        .rise(inRise),
        .fall(inFall)
    );

    // four sensors, two per side, high means actuated
    assign s11 = inLevel[`SMG_IN_ENTRY_A];
    assign s12 = inLevel[`SMG_IN_ENTRY_B];
    assign s21 = inLevel[`SMG_IN_EXIT_A];
    assign s22 = inLevel[`SMG_IN_EXIT_B];
    assign r11 = inRise[`SMG_IN_ENTRY_A];
    assign r12 = inRise[`SMG_IN_ENTRY_B];
    assign r21 = inRise[`SMG_IN_EXIT_A];
    assign r22 = inRise[`SMG_IN_EXIT_B];
    assign f11 = inFall[`SMG_IN_ENTRY_A];
    assign f12 = inFall[`SMG_IN_ENTRY_B];
    assign f21 = inFall[`SMG_IN_EXIT_A];
    assign f22 = inFall[`SMG_IN_EXIT_B];
    assign guardOk = inLevel[`SMG_IN_GUARD];

    assign activate = ctrl[`SMG_CTRL_ACTIVATE];
    assign permit = ctrl[`SMG_CTRL_PERMIT];
    assign startReset = ctrl[`SMG_CTRL_START_RESET];
    assign resetRise = ctrl[`SMG_CTRL_RESET] & ~resetPrev;

    // =================================================================
    // maximum mute time
    assign muted = (state == SMG_FWD_MUTED) || (state == SMG_BWD_MUTED);

    smg_mute_timer #(.TICK_CYCLES(TICK_CYCLES), .TIME_W(`SMG_TIME_W)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(muted),
        .limit(maxTime),
        .expired(expired)
    );

    // =================================================================
    // register bus
    always_comb begin
        gotAw = awHeld || (axiReq.awvalid && axiRsp.awready);
        gotW = wHeld || (axiReq.wvalid && axiRsp.wready);
        wrAddr = awHeld ? awAddr : axiReq.awaddr;
        wrData = wHeld ? wData : axiReq.wdata;
        wrStrb = wHeld ? wStrb : axiReq.wstrb;
        doWrite = gotAw && gotW && !axiRsp.bvalid;
        unique case (wrAddr)
            `SMG_ADDR_CTRL: curWord = 32'(ctrl);
            `SMG_ADDR_MAXTIME: curWord = 32'(maxTime);
            default: curWord = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            wMerged[i*8 +: 8] = wrStrb[i] ? wrData[i*8 +: 8] : curWord[i*8 +: 8];
        end
        wrHit = (wrAddr == `SMG_ADDR_CTRL) || (wrAddr == `SMG_ADDR_MAXTIME);
        rdHit = (axiReq.araddr == `SMG_ADDR_CTRL) || (axiReq.araddr == `SMG_ADDR_MAXTIME)
                || (axiReq.araddr == `SMG_ADDR_STATUS);
        unique case (axiReq.araddr)
            `SMG_ADDR_CTRL: rdWord = 32'(ctrl);
            `SMG_ADDR_MAXTIME: rdWord = 32'(maxTime);
            `SMG_ADDR_STATUS: rdWord = 32'({inLevel, mute_active_out, guarded_out, state});
            default: rdWord = 32'h0;
        endcase

        next_ctrl = ctrl;
        next_maxTime = maxTime;
        next_awHeld = gotAw;
        next_wHeld = gotW;
        next_awAddr = wrAddr;
        next_wData = wrData;
        next_wStrb = wrStrb;
        next_rsp = axiRsp;
        if (axiRsp.bvalid && axiReq.bready) begin
            next_rsp.bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = wrHit ? `SMG_RESP_OKAY : `SMG_RESP_SLVERR;
            if (wrAddr == `SMG_ADDR_CTRL) begin
                next_ctrl = wMerged[`SMG_CTRL_W-1:0];
            end
            if (wrAddr == `SMG_ADDR_MAXTIME) begin
                // out-of-range limits saturate at two hours
                next_maxTime = (wMerged > 32'(MAX_TIME_LIMIT)) ? MAX_TIME_LIMIT
                               : wMerged[`SMG_TIME_W-1:0];
            end
        end
        next_rsp.awready = !next_awHeld && !next_rsp.bvalid;
        next_rsp.wready = !next_wHeld && !next_rsp.bvalid;

        if (axiRsp.rvalid && axiReq.rready) begin
            next_rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && axiRsp.arready) begin
            next_rsp.rvalid = 1'b1;
            next_rsp.rdata = rdWord;
            next_rsp.rresp = rdHit ? `SMG_RESP_OKAY : `SMG_RESP_SLVERR;
        end
        next_rsp.arready = !next_rsp.rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= `SMG_CTRL_RESET_VAL;
            maxTime <= MAX_MUTE_TIME_MS;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= 32'h0;
            wStrb <= 4'h0;
            axiRsp <= '0;
        end else begin
            ctrl <= next_ctrl;
            maxTime <= next_maxTime;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            axiRsp <= next_rsp;
        end
    end

    // =================================================================
    // muting sequence
    always_comb begin
        activeCnt = 3'(s11) + 3'(s12) + 3'(s21) + 3'(s22);
        fwdStart = permit && r11 && !s12 && !s21 && !s22;
        bwdStart = permit && !s11 && !s12 && !s21 && r22;
        freeErr = (!permit && (r11 || r22)) || s12 || s21 || (s11 && s22);
        fwdFirstErr = !permit || !s11 || s21 || s22;
        bwdFirstErr = !permit || !s22 || s11 || s12;
        fwdMute = permit && s11 && r12 && !s21 && !s22;
        bwdMute = permit && !s11 && !s12 && r21 && s22;
        fwdEnd = !s11 && !s12 && f21 && s22;
        bwdEnd = s11 && f12 && !s21 && !s22;
        // a missing carrier or exit released out of order is a bad sequence
        fwdMutedErr = !fwdEnd && ((activeCnt < `SMG_MIN_ACTIVE) || f22 || r11 || r12);
        bwdMutedErr = !bwdEnd && ((activeCnt < `SMG_MIN_ACTIVE) || f11 || r21 || r22);

        next_state = state;
        if (!activate) begin
            next_state = SMG_IDLE;
        end else begin
            unique case (state)
                SMG_IDLE: begin
                    next_state = (startReset && guardOk) ? SMG_FREE : SMG_SAFE;
                end
                SMG_FREE: begin
                    if (freeErr) next_state = SMG_LOCK;
                    else if (!guardOk) next_state = SMG_SAFE;
                    else if (fwdStart) next_state = SMG_FWD_FIRST;
                    else if (bwdStart) next_state = SMG_BWD_FIRST;
                end
                SMG_FWD_FIRST: begin
                    if (fwdFirstErr) next_state = SMG_LOCK;
                    else if (!guardOk) next_state = SMG_SAFE;
                    else if (fwdMute) next_state = SMG_FWD_MUTED;
                end
                SMG_BWD_FIRST: begin
                    if (bwdFirstErr) next_state = SMG_LOCK;
                    else if (!guardOk) next_state = SMG_SAFE;
                    else if (bwdMute) next_state = SMG_BWD_MUTED;
                end
                SMG_FWD_MUTED: begin
                    // permit is no longer looked at here
                    if (fwdMutedErr) next_state = SMG_LOCK;
                    else if (expired) next_state = SMG_LOCK;
                    else if (fwdEnd) next_state = SMG_FREE;
                end
                SMG_BWD_MUTED: begin
                    if (bwdMutedErr) next_state = SMG_LOCK;
                    else if (expired) next_state = SMG_LOCK;
                    else if (bwdEnd) next_state = SMG_FREE;
                end
                SMG_SAFE, SMG_LOCK: begin
                    if (resetRise && guardOk) next_state = SMG_FREE;
                end
                default: next_state = SMG_LOCK;
            endcase
        end
        next_mute = (next_state == SMG_FWD_MUTED) || (next_state == SMG_BWD_MUTED);
        next_guarded = next_mute || (guardOk && ((next_state == SMG_FREE)
                       || (next_state == SMG_FWD_FIRST) || (next_state == SMG_BWD_FIRST)));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= SMG_IDLE;
            resetPrev <= 1'b0;
            guarded_out <= 1'b0;
            mute_active_out <= 1'b0;
        end else begin
            state <= next_state;
            resetPrev <= ctrl[`SMG_CTRL_RESET];
            guarded_out <= next_guarded;
            mute_active_out <= next_mute;
        end
    end

    // =================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_mute_guard_clear: assert property ($rose(mute_active_out) |-> $past(guardOk) && $past(activeCnt) >= `SMG_MIN_ACTIVE)
        else $error("muting began with guard off or one sensor");
    a_permit_gates_start: assert property ((state == SMG_FREE && !permit) |=>
        !(state inside {SMG_FWD_FIRST, SMG_BWD_FIRST}))
        else $error("sequence started without permit");
    a_activate_idle: assert property (!activate |=> state == SMG_IDLE && !mute_active_out && !guarded_out)
        else $error("activate low did not force idle");
    a_mute_out_state: assert property (mute_active_out == muted)
        else $error("mute output disagrees with state");
    a_blocked_guard_low: assert property ((state inside {SMG_SAFE, SMG_LOCK, SMG_IDLE}) |-> !guarded_out)
        else $error("guarded output high while blocked");
    a_end_on_sensor: assert property ((activate && state == SMG_FWD_MUTED && fwdEnd && !expired) |=>
        state == SMG_FREE && !mute_active_out)
        else $error("muting not ended by exit sensor");
    a_timer_lockout: assert property ((activate && muted && expired) |=> state == SMG_LOCK ##1 !mute_active_out)
        else $error("expired mute time did not lock");
    a_lock_holds: assert property ((activate && state == SMG_LOCK && !(resetRise && guardOk)) |=> state == SMG_LOCK)
        else $error("lockout left without reset");
    a_permit_drop_ok: assert property ((activate && state == SMG_BWD_MUTED && !permit && !bwdMutedErr
        && !expired && !bwdEnd) |=> state == SMG_BWD_MUTED)
        else $error("permit drop aborted muting");

endmodule : smg_sequential_muting_guard

// ### smg_far_side.sv
/*
 * far-side model: optical guard switching output and four presence sensors.
 * assumes the bench moves the pins through put() on the design clock.
 */
module smg_far_side (
    // clock
    input wire logic sys_clk,
    // pins toward the guard logic
    output logic guard_ok_in,
    output smg_pkg::smg_sensor_t sensorIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import smg_pkg::*;

    // ========
    // pins
    initial begin
        guard_ok_in = 1'b1;
        sensorIn = '0;
    end

    // pins move just after an edge, so no sample races the change
    task automatic put(input logic [3:0] s, input logic g);
        @(posedge sys_clk);
        sensorIn <= s;
        guard_ok_in <= g;
    endtask : put
endmodule : smg_far_side

// ### smg_sequential_muting_guard_tb_top.sv
/*
 * bench for the sequential muting guard: registers, passes, faults.
 * assumes smg_pkg, the design files and smg_far_side are compiled first.
 */
`include "smg_consts.svh"

module smg_sequential_muting_guard_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import smg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    smg_axil_req_t req = '0;
    smg_axil_rsp_t rsp;
    logic guardOk;
    logic guardedOut;
    logic muteOut;
    smg_sensor_t sensors;
    logic [31:0] rdData;
    logic [1:0] rdResp;
    logic [1:0] wrResp;
    int miscompares = 0;
    int checks = 0;
    // ========
    // rows: sensors exit_b..entry_a, guard, guarded, mute; two sensors kept up while muted
    localparam logic [6:0] ROWS [18] = '{7'h06, 7'h0e, 7'h1f, 7'h1b, 7'h3b, 7'h7b, 7'h73, 7'h67, 7'h46,
        7'h06, 7'h46, 7'h67, 7'h77, 7'h7f, 7'h3f, 7'h1f, 7'h0e, 7'h06};

    always #4 sys_clk = ~sys_clk;

    smg_far_side far (.sys_clk(sys_clk), .guard_ok_in(guardOk), .sensorIn(sensors));
    smg_sequential_muting_guard #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst), .axiReq(req),
        .axiRsp(rsp), .guard_ok_in(guardOk), .sensorIn(sensors), .guarded_out(guardedOut),
        .mute_active_out(muteOut));

    // ========
    // tasks
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        wrResp = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rdData = rsp.rdata;
        rdResp = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    // pin to output takes about five edges; eight leaves margin
    task automatic pins(input logic [3:0] s, input logic g);
        far.put(s, g);
        repeat (8) @(posedge sys_clk);
    endtask : pins

    task automatic state(input logic [7:0] e);
        rd(`SMG_ADDR_STATUS);
        // status also carries pins and outputs above the state byte
        cmp("state", {24'h000000, e}, {24'h000000, rdData[7:0]});
    endtask : state

    // interlock returns to free only on a rise of the reset bit
    task automatic rstcmd;
        wr(`SMG_ADDR_CTRL, 32'h0000000f);
        wr(`SMG_ADDR_CTRL, 32'h00000007);
        repeat (8) @(posedge sys_clk);
    endtask : rstcmd

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // ========
    // sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        cmp("guarded_out", 32'h0, guardedOut);
        cmp("mute_active_out", 32'h0, muteOut);
        state(SMG_IDLE);
        rd(8'h0c);
        cmp("unmapped resp", `SMG_RESP_SLVERR, rdResp);
        cmp("unmapped data", 32'h0, rdData);
        rd(`SMG_ADDR_CTRL);
        cmp("ctrl", `SMG_CTRL_RESET_VAL, rdData);
        wr(`SMG_ADDR_MAXTIME, 32'hffffffff);
        cmp("maxtime bresp", `SMG_RESP_OKAY, wrResp);
        rd(`SMG_ADDR_MAXTIME);
        cmp("maxtime clamp", `SMG_MAX_TIME_MIN * `SMG_MS_PER_MIN, rdData);
        wr(`SMG_ADDR_STATUS, 32'h00000001);
        cmp("status bresp", `SMG_RESP_SLVERR, wrResp);
        $display("test reset done");
        wr(`SMG_ADDR_MAXTIME, 32'h00000064);
        wr(`SMG_ADDR_CTRL, 32'h00000007);
        foreach (ROWS[i]) begin
            pins(ROWS[i][6:3], ROWS[i][2]);
            cmp("guarded_out", ROWS[i][1], guardedOut);
            cmp("mute_active_out", ROWS[i][0], muteOut);
        end
        $display("test passes done");
        pins(4'h2, 1'b1);
        state(SMG_LOCK);
        cmp("mute_active_out", 32'h0, muteOut);
        pins(4'h0, 1'b1);
        state(SMG_LOCK);
        rstcmd;
        state(SMG_FREE);
        $display("test order done");
        wr(`SMG_ADDR_CTRL, 32'h00000005);
        pins(4'h1, 1'b1);
        state(SMG_LOCK);
        pins(4'h0, 1'b1);
        rstcmd;
        $display("test permit done");
        wr(`SMG_ADDR_MAXTIME, 32'h00000006);
        pins(4'h1, 1'b1);
        pins(4'h3, 1'b1);
        cmp("mute_active_out", 32'h1, muteOut);
        wr(`SMG_ADDR_CTRL, 32'h00000005);
        cmp("mute_active_out", 32'h1, muteOut);
        repeat (30) @(posedge sys_clk);
        cmp("mute_active_out", 32'h0, muteOut);
        state(SMG_LOCK);
        pins(4'h0, 1'b1);
        rstcmd;
        state(SMG_FREE);
        $display("test timeout done");
        pins(4'h0, 1'b0);
        cmp("guarded_out", 32'h0, guardedOut);
        state(SMG_SAFE);
        pins(4'h0, 1'b1);
        state(SMG_SAFE);
        rstcmd;
        // guard drops after the first entry sensor: second one must not mute
        pins(4'h1, 1'b1);
        pins(4'h1, 1'b0);
        state(SMG_SAFE);
        pins(4'h3, 1'b0);
        cmp("mute_active_out", 32'h0, muteOut);
        pins(4'h0, 1'b1);
        wr(`SMG_ADDR_CTRL, 32'h00000000);
        repeat (4) @(posedge sys_clk);
        state(SMG_IDLE);
        wr(`SMG_ADDR_CTRL, 32'h00000003);
        repeat (4) @(posedge sys_clk);
        state(SMG_SAFE);
        $display("test guard done");
        end_of_test;
    end

    // the whole run needs well under two thousand cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        miscompares++;
        end_of_test;
    end
endmodule : smg_sequential_muting_guard_tb_top
